// *** bench/spi_master_model.sv ***
// bench model of the serial master that drives whole frames
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input wire logic so_line,
    output var logic cs_n,
    output var logic link_clk,
    output var logic si
);
    import spi_diag_pkg::*;
    initial begin
        cs_n = 1'b1;
        link_clk = 1'b1;
        si = 1'b0;
    end
    // a released data line keeps changing so no stale bit is trusted
    always #15 if (cs_n) si = ~si;
    // clock idles high and stands still outside frames
    task automatic xfer(input frame_word_t w, output frame_word_t r);
        cs_n = 1'b0;
        #300;
        for (int i = 15; i >= 0; i--) begin
            link_clk = 1'b0;
            si = w[i];
            #7.5;
            link_clk = 1'b1;
            r[i] = so_line;
            #7.5;
        end
        #200;
        cs_n = 1'b1;
    endtask
endmodule // spi_master_model
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the command and diagnosis unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spi_diag_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic link_clk, cs_n, si, so, so_oe;
    logic so_hold = 1'b0;
    logic [5:0] par_in = '0, f_ol = '0, f_op = '0, f_by = '0, ch_oh = '0;
    logic chip_oh = 1'b0;
    logic [2:0] early_peak = '0, rise_dn = '0;
    logic [5:0] ch_on;
    logic fault_n, flag_pin, restart, and_comb, latch_mode;
    setup_word_t reg1, reg2, reg3;
    logic [2:0] lowside, ol_dis;
    wire so_line = so_oe ? so : ~so_hold;
    int bad_count = 0, checks = 0, seed = 32'hf9b8;
    logic [11:0] m_reg [3];
    logic [11:0] m_chan;
    logic [5:0] m_sw, m_hot;
    logic [1:0] m_cd [6];
    logic m_oh;
    frame_word_t rx;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (so_oe) so_hold <= so;

    spi_command_and_diagnosis_unit DUT (.core_clk(core_clk), .rst(rst),
        .link_clk(link_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .par_in(par_in), .fault_overload(f_ol), .fault_openload(f_op),
        .fault_bypass(f_by), .ch_overheat(ch_oh), .chip_overheat(chip_oh),
        .early_peak(early_peak), .rise_done(rise_dn), .ch_on(ch_on),
        .fault_n(fault_n), .ch6_diag_or_heat_flag_pin(flag_pin),
        .filter_restart_r(restart), .regulator1_setup_r(reg1),
        .regulator2_setup_r(reg2), .regulator3_setup_r(reg3),
        .lowside_select(lowside), .openload_bypass_detect_disable(ol_dis),
        .and_combine(and_comb), .overheat_latch_mode(latch_mode));
    spi_master_model master (.so_line(so_line), .cs_n(cs_n),
        .link_clk(link_clk), .si(si));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic frame_word_t diag_exp();
        return {m_cd[5], m_cd[4], m_cd[3], m_cd[2], m_cd[1], m_cd[0],
                m_oh, chip_oh, 2'b11};
    endfunction
    function automatic logic fault_exp();
        frame_word_t w;
        w = diag_exp();
        return w[15:4] == 12'hFFF;
    endfunction
    task automatic chk_setup();
        logic [5:0] on_exp;
        on_exp = m_chan[5] ? (par_in & m_sw) : (par_in | m_sw);
        chk("reg1", m_reg[0], reg1);
        chk("reg2", m_reg[1], reg2);
        chk("reg3", m_reg[2], reg3);
        chk("low", {m_chan[11], m_chan[9], m_chan[7]}, lowside);
        chk("oldis", {m_chan[10], m_chan[8], m_chan[6]}, ol_dis);
        chk("and", m_chan[5], and_comb);
        chk("latch", m_chan[4], latch_mode);
        chk("ch_on", on_exp, ch_on);
        chk("fault_n", fault_exp(), fault_n);
        chk("flag", m_chan[3] ? !(m_oh | chip_oh) : m_cd[5] == 2'b11,
            flag_pin);
    endtask
    // model of one committed frame; only defined codes take effect
    task automatic frame(input logic [3:0] c, input logic [11:0] d);
        frame_word_t e;
        int n;
        logic v;
        n = 0;
        v = c[3] && c != 4'hE;
        e = diag_exp();
        master.xfer({c, d}, rx);
        repeat (20) begin
            @(negedge core_clk);
            if (restart === 1'b1) n++;
        end
        chk("rx", e, rx);
        if (v) begin
            if (c == 4'h8) begin
                m_reg = '{3{12'h040}};
                m_chan = '0;
                m_sw = '0;
            end
            if (c >= 4'h9 && c <= 4'hB) m_reg[c - 4'h9] = d & 12'hFFE;
            if (c == 4'hC) m_chan = d & 12'hFF8;
            if (c == 4'hD) m_sw = d[11:6];
            if ((m_hot & m_sw) == 6'h00) m_oh = 1'b0;
            m_hot = m_hot & m_sw;
            m_cd = '{6{2'b11}};
        end
        chk("restart", v, n[15:0]);
        chk_setup();
    endtask
    // kinds: overload, open load, bypass, early peak
    task automatic hit(input int kind, input int ch);
        @(negedge core_clk);
        case (kind)
            0: f_ol[ch] = 1'b1;
            1: f_op[ch] = 1'b1;
            2: f_by[ch] = 1'b1;
            default: early_peak[ch] = 1'b1;
        endcase
        @(negedge core_clk);
        {f_ol, f_op, f_by, early_peak} = '0;
        m_cd[ch] = 2'h2 >> (kind % 3);
        repeat (3) @(negedge core_clk);
        chk("fault_n", fault_exp(), fault_n);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge core_clk);
        bad_count++;
        complete_run();
    end
    initial begin
        m_reg = '{3{12'h040}};
        m_chan = '0;
        m_sw = '0;
        m_hot = '0;
        m_oh = 1'b0;
        m_cd = '{6{2'b11}};
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        repeat (6) @(negedge core_clk);
        chk_setup();
        frame(4'hF, 12'hABC);
        for (int k = 0; k < 6; k++) begin
            frame(4'(9 + k % 3), 12'($random(seed)));
            frame(4'hC, 12'($random(seed)));
        end
        for (int k = 0; k < 4; k++) begin
            frame(4'hC, {6'h00, k[0], 5'h00});
            frame(4'hD, 12'($random(seed)));
            par_in = 6'($random(seed));
            repeat (4) @(negedge core_clk);
            chk_setup();
        end
        frame(4'h8, 12'hFFF);
        par_in = '0;
        repeat (4) @(negedge core_clk);
        for (int k = 0; k < 8; k++) begin
            hit(0, k % 6);
            hit(1, (k + 1) % 6);
            hit(2, k % 6);
            frame(4'(k), 12'($random(seed)));
            frame(4'hE, 12'h000);
            frame(4'hF, 12'h000);
        end
        frame(4'hC, 12'h008);
        frame(4'hD, 12'h080);
        ch_oh[1] = 1'b1;
        chip_oh = 1'b1;
        repeat (3) @(negedge core_clk);
        ch_oh = '0;
        m_oh = 1'b1;
        m_hot = 6'h02;
        m_cd[1] = 2'b10;
        repeat (3) @(negedge core_clk);
        chk_setup();
        frame(4'hF, 12'h000);
        chip_oh = 1'b0;
        repeat (4) @(negedge core_clk);
        frame(4'hF, 12'h000);
        frame(4'hD, 12'h000);
        frame(4'hF, 12'h000);
        frame(4'h9, 12'hC00);
        frame(4'hD, 12'h040);
        hit(3, 0);
        frame(4'hF, 12'h000);
        // once the first rise has finished, an early peak is not a fault
        rise_dn[0] = 1'b1;
        @(negedge core_clk);
        rise_dn = '0;
        early_peak[0] = 1'b1;
        @(negedge core_clk);
        early_peak = '0;
        repeat (3) @(negedge core_clk);
        chk("fault_n", fault_exp(), fault_n);
        complete_run();
    end
endmodule // testbench
`default_nettype wire

// *** rtl/spi_command_and_diagnosis_unit.sv ***
// serial command decoder with diagnosis register
`timescale 1ns/1ps
`default_nettype none
`include "spi_diag_params.svh"

module spi_command_and_diagnosis_unit (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic [5:0] par_in,
    input wire logic [5:0] fault_overload,
    input wire logic [5:0] fault_openload,
    input wire logic [5:0] fault_bypass,
    input wire logic [5:0] ch_overheat,
    input wire logic chip_overheat,
    input wire logic [2:0] early_peak,
    input wire logic [2:0] rise_done,
    output logic [5:0] ch_on,
    output logic fault_n,
    output logic ch6_diag_or_heat_flag_pin,
    output logic filter_restart_r,
    output spi_diag_pkg::setup_word_t regulator1_setup_r,
    output spi_diag_pkg::setup_word_t regulator2_setup_r,
    output spi_diag_pkg::setup_word_t regulator3_setup_r,
    output logic [2:0] lowside_select,
    output logic [2:0] openload_bypass_detect_disable,
    output logic and_combine,
    output logic overheat_latch_mode
);
    import spi_diag_pkg::*;

    // command codes the decoder accepts; everything else is dropped
    function automatic logic cmd_valid(input logic [3:0] cmd);
        cmd_valid = (cmd == `CMD_DEFAULT) || (cmd == `CMD_REG1) ||
                    (cmd == `CMD_REG2) || (cmd == `CMD_REG3) ||
                    (cmd == `CMD_CHAN) || (cmd == `CMD_SWITCH) ||
                    (cmd == `CMD_DIAG);
    endfunction

    function automatic logic [1:0] mode_of(input setup_word_t w);
        mode_of = w[`MODE_HI:`MODE_LO];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    frame_state_t state_r;
    frame_word_t rx_word;
    frame_word_t tx_word_r;
    frame_word_t diag_word;
    logic rx_tog;
    logic link_rst_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_seen_r;
    logic chip_ot_s1_r;
    logic chip_ot_s2_r;
    logic [5:0] par_s1_r;
    logic [5:0] par_s2_r;
    logic [3:0] cmd;
    logic got_word;
    logic commit;
    logic commit_valid;
    setup_word_t chan_setup_r;
    logic [5:0] switch_bits_r;
    logic [11:0] codes_r;
    logic [11:0] codes_nxt;
    logic [5:0] ot_src_r;
    logic [5:0] ch_on_d_r;
    logic [2:0] first_rise_r;
    logic [2:0] early_ok;
    logic [2:0] reg_active;
    logic [5:0] dis_mask;
    logic [5:0] hl_ev;
    logic [5:0] lh_ev;
    logic [5:0] ll_ev;
    logic ch_ot_flag;

    ////////////////////////////////////////////////////////////////////////
    // link side
    spi_link_shifter u_link (
        .link_clk(link_clk),
        .link_rst(link_rst_r),
        .cs_n(cs_n),
        .si(si),
        .tx_word(tx_word_r),
        .rx_word_r(rx_word),
        .rx_tog_r(rx_tog),
        .so(so),
        .so_oe(so_oe)
    );

    always_ff @(posedge core_clk) begin
        link_rst_r <= rst;
    end

    // pins and the word toggle enter through two flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            chip_ot_s1_r <= 1'b0;
            chip_ot_s2_r <= 1'b0;
            par_s1_r <= 6'h00;
            par_s2_r <= 6'h00;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            tog_s1_r <= rx_tog;
            tog_s2_r <= tog_s1_r;
            chip_ot_s1_r <= chip_overheat;
            chip_ot_s2_r <= chip_ot_s1_r;
            par_s1_r <= par_in;
            par_s2_r <= par_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= FS_IDLE;
        end else begin
            case (state_r)
                FS_IDLE: begin
                    if (!cs_s2_r) begin
                        state_r <= FS_FRAME;
                    end
                end
                FS_FRAME: begin
                    if (cs_s2_r) begin
                        state_r <= FS_COMMIT;
                    end
                end
                FS_COMMIT: state_r <= FS_IDLE;
                default: state_r <= FS_IDLE;
            endcase
        end
    end

    // snapshot taken as the frame opens; held until the next frame
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_word_r <= `DIAG_IDLE;
        end else if (state_r == FS_IDLE && !cs_s2_r) begin
            tx_word_r <= diag_word;
        end
    end

    // the word toggle settles long before chip select rises (lag time)
    always_ff @(posedge core_clk) begin
        if (rst || commit) begin
            tog_seen_r <= tog_s2_r;
        end
    end
    assign commit = (state_r == FS_COMMIT);
    assign got_word = (tog_s2_r != tog_seen_r);
    assign cmd = rx_word[`CMD_HI:`CMD_LO];
    // short frames and undefined codes leave everything as it was
    assign commit_valid = commit && got_word && cmd_valid(cmd);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            filter_restart_r <= 1'b0;
        end else begin
            filter_restart_r <= commit_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // setup registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            regulator1_setup_r <= `REG_DEFAULT;
            regulator2_setup_r <= `REG_DEFAULT;
            regulator3_setup_r <= `REG_DEFAULT;
        end else if (commit_valid) begin
            if (cmd == `CMD_DEFAULT) begin
                regulator1_setup_r <= `REG_DEFAULT;
                regulator2_setup_r <= `REG_DEFAULT;
                regulator3_setup_r <= `REG_DEFAULT;
            end else if (cmd == `CMD_REG1) begin
                regulator1_setup_r <= rx_word[`DATA_HI:0] & `REG_DATA_MASK;
            end else if (cmd == `CMD_REG2) begin
                regulator2_setup_r <= rx_word[`DATA_HI:0] & `REG_DATA_MASK;
            end else if (cmd == `CMD_REG3) begin
                regulator3_setup_r <= rx_word[`DATA_HI:0] & `REG_DATA_MASK;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            chan_setup_r <= `CHAN_DEFAULT;
        end else if (commit_valid && cmd == `CMD_DEFAULT) begin
            chan_setup_r <= `CHAN_DEFAULT;
        end else if (commit_valid && cmd == `CMD_CHAN) begin
            chan_setup_r <= rx_word[`DATA_HI:0] & `CHAN_DATA_MASK;
        end
    end

    // a diagnosis-only frame matches none of these branches
    always_ff @(posedge core_clk) begin
        if (rst) begin
            switch_bits_r <= `SWITCH_DEFAULT;
        end else if (commit_valid && cmd == `CMD_DEFAULT) begin
            switch_bits_r <= `SWITCH_DEFAULT;
        end else if (commit_valid && cmd == `CMD_SWITCH) begin
            switch_bits_r <= rx_word[`SW_HI:`SW_LO];
        end
    end

    // decode: one selects lowside, detection off, AND, latch, flag
    assign lowside_select = {chan_setup_r[`CFG_LS6], chan_setup_r[`CFG_LS5],
                             chan_setup_r[`CFG_LS4]};
    assign openload_bypass_detect_disable = {chan_setup_r[`CFG_DIS6],
        chan_setup_r[`CFG_DIS5], chan_setup_r[`CFG_DIS4]};
    assign and_combine = chan_setup_r[`CFG_AND];
    assign overheat_latch_mode = chan_setup_r[`CFG_LATCH];

    // pin and serial bit; a one in the serial bit means on
    assign ch_on = and_combine ? (par_s2_r & switch_bits_r)
                               : (par_s2_r | switch_bits_r);

    ////////////////////////////////////////////////////////////////////////
    // early current rise check, only on the first edge after turn-on
    assign reg_active = {mode_of(regulator3_setup_r) != `MODE_NONE,
                         mode_of(regulator2_setup_r) != `MODE_NONE,
                         mode_of(regulator1_setup_r) != `MODE_NONE};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ch_on_d_r <= 6'h00;
            first_rise_r <= 3'h0;
        end else begin
            ch_on_d_r <= ch_on;
            first_rise_r <= (first_rise_r & ~rise_done) |
                            (ch_on[2:0] & ~ch_on_d_r[2:0]);
        end
    end
    assign early_ok = early_peak & first_rise_r & reg_active;

    ////////////////////////////////////////////////////////////////////////
    // diagnosis codes
    assign dis_mask = {openload_bypass_detect_disable, 3'h0};
    assign hl_ev = fault_overload | (ch_overheat & ch_on) |
                   {3'h0, early_ok};
    assign lh_ev = fault_openload & ~ch_on & ~dis_mask;
    assign ll_ev = fault_bypass & ~dis_mask;

    // an event in the clearing cycle is applied after the clear
    always_comb begin
        codes_nxt = commit_valid ? `CODES_CLEAR : codes_r;
        for (int i = 0; i < 6; i++) begin
            if (ll_ev[i]) begin
                codes_nxt[2*i +: 2] = `CODE_LL;
            end else if (hl_ev[i]) begin
                codes_nxt[2*i +: 2] = `CODE_HL;
            end else if (lh_ev[i]) begin
                codes_nxt[2*i +: 2] = `CODE_LH;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            codes_r <= `CODES_CLEAR;
        end else begin
            codes_r <= codes_nxt;
        end
    end

    // channel flag survives clearing; ends once each hot channel went off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ot_src_r <= 6'h00;
        end else begin
            ot_src_r <= (ot_src_r & ch_on) | (ch_overheat & ch_on);
        end
    end

    assign ch_ot_flag = |ot_src_r;
    assign diag_word = {codes_r, ch_ot_flag, chip_ot_s2_r,
                        `LOW_ONES};
    assign fault_n = (codes_r == `CODES_CLEAR);
    assign ch6_diag_or_heat_flag_pin = chan_setup_r[`CFG_FLAG] ?
        ~(ch_ot_flag | chip_ot_s2_r) :
        (codes_r[`CH6_HI:`CH6_LO] == `CODE_OK);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_drop_invalid: assert property (
        commit && !(got_word && cmd_valid(cmd)) |=>
            $stable(regulator1_setup_r) && $stable(chan_setup_r) &&
            $stable(switch_bits_r) && $stable(filter_restart_r))
        else $error("invalid frame changed state");
    chk_clear_valid: assert property (
        commit_valid && ll_ev == 6'h00 && hl_ev == 6'h00 &&
        lh_ev == 6'h00 |=> codes_r == `CODES_CLEAR && filter_restart_r)
        else $error("valid frame did not clear diagnosis");
    chk_low_ones: assert property (
        diag_word[1:0] == `LOW_ONES && tx_word_r[1:0] == `LOW_ONES)
        else $error("low diagnosis bits not one");
    chk_fault_pin: assert property (
        ll_ev[0] |=> !fault_n && codes_r[1:0] == `CODE_LL)
        else $error("fault not latched");
    chk_default_cmd: assert property (
        commit_valid && cmd == `CMD_DEFAULT |=>
            regulator2_setup_r == `REG_DEFAULT &&
            chan_setup_r == `CHAN_DEFAULT && switch_bits_r == `SWITCH_DEFAULT)
        else $error("defaults not restored");
    chk_switch_load: assert property (
        commit_valid && cmd == `CMD_SWITCH |=>
            switch_bits_r == $past(rx_word[`SW_HI:`SW_LO]))
        else $error("switch bits not loaded");
    chk_on_combine: assert property (
        ch_on == (chan_setup_r[`CFG_AND] ? (par_s2_r & switch_bits_r)
                                         : (par_s2_r | switch_bits_r)))
        else $error("channel on combine wrong");
    chk_chip_flag: assert property (
        chip_ot_s2_r && state_r == FS_IDLE && !cs_s2_r |=> tx_word_r[2])
        else $error("chip overheat flag missing");
    chk_ch_flag_hold: assert property (
        ch_ot_flag && commit_valid && |(ot_src_r & ch_on) |=> ch_ot_flag)
        else $error("channel flag cleared by command");

endmodule // spi_command_and_diagnosis_unit
`default_nettype wire

// *** rtl/spi_diag_params.svh ***
// constants for the command and diagnosis unit
`ifndef SPI_DIAG_PARAMS_SVH
`define SPI_DIAG_PARAMS_SVH

// frame layout
`define FRAME_MSB 15
`define CMD_HI 15
`define CMD_LO 12
`define DATA_HI 11
`define BIT_CNT_MAX 5'h10
`define BIT_CNT_ONE 5'h01
`define BIT_CNT_ZERO 5'h00
`define FALL_CNT_MAX 4'hF
`define FALL_CNT_ONE 4'h1

// command codes
`define CMD_DEFAULT 4'h8
`define CMD_REG1 4'h9
`define CMD_REG2 4'hA
`define CMD_REG3 4'hB
`define CMD_CHAN 4'hC
`define CMD_SWITCH 4'hD
`define CMD_DIAG 4'hF

// reset values and data masks of the setup registers
`define REG_DEFAULT 12'h040
`define CHAN_DEFAULT 12'h000
`define SWITCH_DEFAULT 6'h00
`define REG_DATA_MASK 12'hFFE
`define CHAN_DATA_MASK 12'hFF8

// field positions
`define MODE_HI 11
`define MODE_LO 10
`define MODE_NONE 2'h0
`define CFG_LS6 11
`define CFG_DIS6 10
`define CFG_LS5 9
`define CFG_DIS5 8
`define CFG_LS4 7
`define CFG_DIS4 6
`define CFG_AND 5
`define CFG_LATCH 4
`define CFG_FLAG 3
`define SW_HI 11
`define SW_LO 6

// diagnosis word
`define CODE_OK 2'h3
`define CODE_HL 2'h2
`define CODE_LH 2'h1
`define CODE_LL 2'h0
`define CODES_CLEAR 12'hFFF
`define LOW_ONES 2'h3
`define DIAG_IDLE 16'hFFFF
`define CH6_HI 11
`define CH6_LO 10

`endif

// *** rtl/spi_diag_pkg.sv ***
// types shared by the command and diagnosis unit
package spi_diag_pkg;
    typedef enum logic [2:0] {
        FS_IDLE = 3'b001,
        FS_FRAME = 3'b010,
        FS_COMMIT = 3'b100
    } frame_state_t;
    typedef logic [11:0] setup_word_t;
    typedef logic [15:0] frame_word_t;
    typedef logic [1:0] diag_code_t;
endpackage

// *** rtl/spi_link_shifter.sv ***
// serial shifter running on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "spi_diag_params.svh"

module spi_link_shifter (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic cs_n,
    input wire logic si,
    input wire spi_diag_pkg::frame_word_t tx_word,
    output spi_diag_pkg::frame_word_t rx_word_r,
    output logic rx_tog_r,
    output logic so,
    output logic so_oe
);
    import spi_diag_pkg::*;

    logic [4:0] bit_cnt_r;
    logic [3:0] fall_cnt_r;
    frame_word_t shift_r;

    ////////////////////////////////////////////////////////////////////////
    // input side: msb first on the rising edge
    // counters are cleared by chip select itself, since the link clock
    // stands still between frames and no edge is left to clear them
    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_r <= 5'h00;
        end else if (bit_cnt_r != `BIT_CNT_MAX) begin
            bit_cnt_r <= bit_cnt_r + `BIT_CNT_ONE;
        end
    end

    always_ff @(posedge link_clk) begin
        shift_r <= {shift_r[`FRAME_MSB-1:0], si};
    end

    // a complete word is handed over with a toggle; extra bits are ignored
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            rx_word_r <= `DIAG_IDLE;
            rx_tog_r <= 1'b0;
        end else if (!cs_n && bit_cnt_r == `BIT_CNT_MAX - `BIT_CNT_ONE) begin
            rx_word_r <= {shift_r[`FRAME_MSB-1:0], si};
            rx_tog_r <= ~rx_tog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output side: next diagnosis bit after each falling edge
    // the fall ahead of the first rise must leave the msb standing,
    // otherwise the master would sample bit 14 first
    always_ff @(negedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            fall_cnt_r <= 4'h0;
        end else if (bit_cnt_r != `BIT_CNT_ZERO &&
                     fall_cnt_r != `FALL_CNT_MAX) begin
            fall_cnt_r <= fall_cnt_r + `FALL_CNT_ONE;
        end
    end

    // tx_word is held steady by the core for the whole frame
    assign so = tx_word[`FALL_CNT_MAX - fall_cnt_r];
    assign so_oe = ~cs_n;

endmodule // spi_link_shifter
`default_nettype wire
